/* common/phy_event_irq_consts.vh */
// constants for the phy event interrupt unit
// -----------------------------------------------------------------
// Overview of operation
// (RULE1) global enable bit 1 permits event interrupts
// (RULE2) select bit 0 high: pin is interrupt
// (RULE3) select bit 0 low: pin is powerdown input
// (RULE4) interrupt drives shared pin low
// (RULE5) flags latch events, cleared by reading
// (RULE6) flags set regardless of any enable
// (RULE7) interrupt needs event enable, bits 1, 0
// (RULE8) link change sets bit 13, enable 5
// (RULE9) speed change sets bit 12, enable 4
// (RULE10) duplex change sets bit 11, enable 3
// (RULE11) autoneg complete sets bit 10, enable 2
// (RULE12) false carrier half full: bit 9, enable 1
// (RULE13) rx error half full: bit 8, enable 0
// (RULE14) bits 15:14, 7:6 read zero, ignore writes
// (RULE15) false carrier counter above 7Fh is half full
// (RULE16) rx error counter above 7FFFh is half full
// (RULE17) interrupt holds until enabled flags cleared
// -----------------------------------------------------------------
`ifndef PHY_EVENT_IRQ_CONSTS_VH
`define PHY_EVENT_IRQ_CONSTS_VH

// -----------------------------------------------------------------
// register indices, byte address is four times the index
// -----------------------------------------------------------------
`define CTRL_INDEX 6'h11
`define STAT_INDEX 6'h12

// -----------------------------------------------------------------
// control register fields
// -----------------------------------------------------------------
`define CTRL_PIN_SEL_BIT 0
`define CTRL_INT_EN_BIT 1
`define CTRL_RESET 2'h0

// -----------------------------------------------------------------
// status and enable register fields
// -----------------------------------------------------------------
`define FLAG_LSB 8
`define FLAG_MSB 13
`define EN_LSB 0
`define EN_MSB 5
`define NUM_EVENTS 6
`define EVT_RX_ERR 0
`define EVT_FALSE_CARRIER 1
`define EVT_AUTONEG 2
`define EVT_DUPLEX 3
`define EVT_SPEED 4
`define EVT_LINK 5
`define EVENT_RESET 6'h00

// -----------------------------------------------------------------
// counter half-full thresholds
// -----------------------------------------------------------------
`define FC_HALF_FULL 8'h7F
`define RE_HALF_FULL 16'h7FFF

`endif

/* core/phy_event_interrupt_unit.v */
// phy event interrupt unit: event flags, enables, apb slave and pin
`include "phy_event_irq_consts.vh"

module phy_event_interrupt_unit #(
  parameter FC_W = 8,
  parameter RE_W = 16
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire link_status,
  input wire speed_status,
  input wire duplex_status,
  input wire autoneg_complete,
  input wire [FC_W-1:0] false_carrier_counter,
  input wire [RE_W-1:0] rx_error_counter,
  input wire irq_or_powerdown_pin_in,
  output wire irq_or_powerdown_pin_out,
  output wire irq_or_powerdown_pin_oe,
  output wire powerdown_req,
  output wire irq
);

  // -----------------------------------------------------------------
  // declarations
  // -----------------------------------------------------------------
  reg [1:0] ctrl_reg;
  reg [1:0] ctrl_next;
  reg [`NUM_EVENTS-1:0] flag_reg;
  reg [`NUM_EVENTS-1:0] flag_next;
  reg [`NUM_EVENTS-1:0] enable_reg;
  reg [`NUM_EVENTS-1:0] enable_next;
  reg [31:0] prdata_reg;
  reg [31:0] prdata_next;
  reg pready_reg;
  reg pslverr_reg;
  reg pslverr_next;
  reg [`NUM_EVENTS-1:0] shown_reg;
  reg [`NUM_EVENTS-1:0] shown_next;
  reg link_prev_reg;
  reg speed_prev_reg;
  reg duplex_prev_reg;
  reg autoneg_prev_reg;
  reg fc_half_prev_reg;
  reg re_half_prev_reg;
  reg primed_reg;
  reg pin_meta_reg;
  reg pin_sync_reg;
  reg irq_reg;
  reg pin_drive_low_reg;
  reg pin_oe_reg;
  reg powerdown_reg;

  wire setup_phase;
  wire access_done;
  wire wr_done;
  wire rd_done;
  wire hit_ctrl;
  wire hit_stat;
  wire mapped;
  wire fc_half;
  wire re_half;
  wire [`NUM_EVENTS-1:0] events;
  wire [`NUM_EVENTS-1:0] w1c_mask;
  wire [`NUM_EVENTS-1:0] read_mask;
  wire irq_next;
  wire [`NUM_EVENTS-1:0] clear_mask;
  wire [`NUM_EVENTS-1:0] pending;
  wire pin_irq_next;

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  // a change of a level status; needs one sample first so reset
  // release does not look like an event
  function change_seen;
    input now_val;
    input prev_val;
    input primed;
    begin
      change_seen = primed & (now_val ^ prev_val);
    end
  endfunction

  // a rise of a level condition
  function rise_seen;
    input now_val;
    input prev_val;
    input primed;
    begin
      rise_seen = primed & now_val & ~prev_val;
    end
  endfunction

  // address match on a word index; the low address bits must be zero
  // since each register takes one aligned word
  function addr_hit;
    input [7:0] addr;
    input [5:0] index;
    begin
      addr_hit = (addr[7:2] == index) & (addr[1:0] == 2'h0);
    end
  endfunction

  // read image of the status register; reserved bits stay zero
  function [31:0] status_word;
    input [`NUM_EVENTS-1:0] flags;
    input [`NUM_EVENTS-1:0] enables;
    begin
      status_word = 32'h0000_0000;
      status_word[`FLAG_MSB:`FLAG_LSB] = flags;
      status_word[`EN_MSB:`EN_LSB] = enables;
    end
  endfunction

  // read image of the control register
  function [31:0] ctrl_word;
    input [1:0] ctrl;
    begin
      ctrl_word = 32'h0000_0000;
      ctrl_word[`CTRL_INT_EN_BIT:`CTRL_PIN_SEL_BIT] = ctrl;
    end
  endfunction

  // one flag: hold unless cleared, and a new event always wins
  function flag_bit;
    input old_val;
    input clr;
    input set;
    begin
      flag_bit = (old_val & ~clr) | set;
    end
  endfunction

  // -----------------------------------------------------------------
  // apb decode
  // -----------------------------------------------------------------
  // read data is registered during the setup cycle, so there is no wait
  // state and every transfer takes exactly one access cycle
  assign setup_phase = psel & ~penable;
  assign access_done = psel & penable & pready_reg;
  assign hit_ctrl = addr_hit(paddr, `CTRL_INDEX);
  assign hit_stat = addr_hit(paddr, `STAT_INDEX);
  assign mapped = hit_ctrl | hit_stat;
  assign wr_done = access_done & pwrite & mapped;
  assign rd_done = access_done & ~pwrite & hit_stat;

  // -----------------------------------------------------------------
  // apb outputs
  // -----------------------------------------------------------------
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  // -----------------------------------------------------------------
  // event detection
  // -----------------------------------------------------------------
  assign fc_half = false_carrier_counter > `FC_HALF_FULL; // [RULE15]
  assign re_half = rx_error_counter > `RE_HALF_FULL; // [RULE16]

  assign events[`EVT_LINK] =
    change_seen(link_status, link_prev_reg, primed_reg); // [RULE8]
  assign events[`EVT_SPEED] =
    change_seen(speed_status, speed_prev_reg, primed_reg); // [RULE9]
  assign events[`EVT_DUPLEX] =
    change_seen(duplex_status, duplex_prev_reg, primed_reg); // [RULE10]
  assign events[`EVT_AUTONEG] =
    rise_seen(autoneg_complete, autoneg_prev_reg, primed_reg); // [RULE11]
  assign events[`EVT_FALSE_CARRIER] =
    rise_seen(fc_half, fc_half_prev_reg, primed_reg); // [RULE12]
  assign events[`EVT_RX_ERR] =
    rise_seen(re_half, re_half_prev_reg, primed_reg); // [RULE13]

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_prev_reg <= 1'b0;
      speed_prev_reg <= 1'b0;
      duplex_prev_reg <= 1'b0;
      autoneg_prev_reg <= 1'b0;
      fc_half_prev_reg <= 1'b0;
      re_half_prev_reg <= 1'b0;
      primed_reg <= 1'b0;
    end else begin
      link_prev_reg <= link_status;
      speed_prev_reg <= speed_status;
      duplex_prev_reg <= duplex_status;
      autoneg_prev_reg <= autoneg_complete;
      fc_half_prev_reg <= fc_half;
      re_half_prev_reg <= re_half;
      primed_reg <= 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // flag clearing
  // -----------------------------------------------------------------
  // a read clears only the flags it actually returned, so an event
  // landing between setup and access is kept for the next read
  assign read_mask = rd_done ? shown_reg : {`NUM_EVENTS{1'b0}}; // [RULE5]
  assign w1c_mask = (wr_done & hit_stat & pstrb[1]) ?
    pwdata[`FLAG_MSB:`FLAG_LSB] : {`NUM_EVENTS{1'b0}};

  // -----------------------------------------------------------------
  // next-state logic for registers
  // -----------------------------------------------------------------
  always @* begin
    ctrl_next = ctrl_reg;
    enable_next = enable_reg;
    if (wr_done && hit_ctrl && pstrb[0]) begin
      ctrl_next = pwdata[1:0];
    end
    if (wr_done && hit_stat && pstrb[0]) begin
      enable_next = pwdata[`EN_MSB:`EN_LSB]; // [RULE14]
    end
  end

  // -----------------------------------------------------------------
  // status flags
  // -----------------------------------------------------------------
  // set beats clear, and no enable gates the setting
  assign clear_mask = read_mask | w1c_mask;

  always @* begin
    flag_next[`EVT_LINK] = flag_bit(flag_reg[`EVT_LINK],
      clear_mask[`EVT_LINK], events[`EVT_LINK]); // [RULE6]
    flag_next[`EVT_SPEED] = flag_bit(flag_reg[`EVT_SPEED],
      clear_mask[`EVT_SPEED], events[`EVT_SPEED]); // [RULE6]
    flag_next[`EVT_DUPLEX] = flag_bit(flag_reg[`EVT_DUPLEX],
      clear_mask[`EVT_DUPLEX], events[`EVT_DUPLEX]); // [RULE6]
    flag_next[`EVT_AUTONEG] = flag_bit(flag_reg[`EVT_AUTONEG],
      clear_mask[`EVT_AUTONEG], events[`EVT_AUTONEG]); // [RULE6]
    flag_next[`EVT_FALSE_CARRIER] = flag_bit(flag_reg[`EVT_FALSE_CARRIER],
      clear_mask[`EVT_FALSE_CARRIER], events[`EVT_FALSE_CARRIER]); // [RULE6]
    flag_next[`EVT_RX_ERR] = flag_bit(flag_reg[`EVT_RX_ERR],
      clear_mask[`EVT_RX_ERR], events[`EVT_RX_ERR]); // [RULE6]
  end

  // -----------------------------------------------------------------
  // read data
  // -----------------------------------------------------------------
  always @* begin
    prdata_next = prdata_reg;
    pslverr_next = 1'b0;
    shown_next = shown_reg;
    if (setup_phase) begin
      prdata_next = 32'h0000_0000;
      shown_next = {`NUM_EVENTS{1'b0}};
      pslverr_next = ~mapped;
      if (hit_ctrl) begin
        prdata_next = ctrl_word(ctrl_reg);
      end
      if (hit_stat) begin
        // bits 15:14 and 7:6 stay zero
        prdata_next = status_word(flag_reg, enable_reg); // [RULE14]
        shown_next = flag_reg;
      end
      if (pwrite) begin
        prdata_next = 32'h0000_0000;
        shown_next = {`NUM_EVENTS{1'b0}};
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `CTRL_RESET;
      enable_reg <= `EVENT_RESET;
      flag_reg <= `EVENT_RESET;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      shown_reg <= `EVENT_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
      enable_reg <= enable_next;
      flag_reg <= flag_next;
      prdata_reg <= prdata_next;
      pready_reg <= setup_phase;
      pslverr_reg <= pslverr_next;
      shown_reg <= shown_next;
    end
  end

  // -----------------------------------------------------------------
  // interrupt generation
  // -----------------------------------------------------------------
  // level stays up while the global enable is set and any enabled flag is pending
  assign pending = flag_reg & enable_reg;
  assign irq_next = ctrl_reg[`CTRL_INT_EN_BIT] & (|pending); // [RULE1] [RULE7] [RULE17]

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  assign irq = irq_reg;

  // -----------------------------------------------------------------
  // shared pin output
  // -----------------------------------------------------------------
  // the pin only shows the interrupt in output mode; in input mode it
  // must stay undriven or the host could not request powerdown
  assign pin_irq_next = irq_next & ctrl_reg[`CTRL_PIN_SEL_BIT]; // [RULE7]

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_drive_low_reg <= 1'b0;
      pin_oe_reg <= 1'b0;
    end else begin
      pin_oe_reg <= ctrl_reg[`CTRL_PIN_SEL_BIT]; // [RULE2] [RULE3]
      pin_drive_low_reg <= pin_irq_next;
    end
  end

  // active low: driven low while interrupting in output mode, else high
  assign irq_or_powerdown_pin_out = ~pin_drive_low_reg; // [RULE4]
  assign irq_or_powerdown_pin_oe = pin_oe_reg;

  // -----------------------------------------------------------------
  // powerdown input
  // -----------------------------------------------------------------
  // the pin is asynchronous, so two flops before anything reads it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_reg <= 1'b1;
      pin_sync_reg <= 1'b1;
      powerdown_reg <= 1'b0;
    end else begin
      pin_meta_reg <= irq_or_powerdown_pin_in;
      pin_sync_reg <= pin_meta_reg;
      powerdown_reg <= ~ctrl_reg[`CTRL_PIN_SEL_BIT] & ~pin_sync_reg; // [RULE3]
    end
  end

  assign powerdown_req = powerdown_reg;

endmodule

/* tb/phy_event_irq_chk.sv */
// port assertions for the phy event interrupt unit
module phy_event_irq_chk (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire irq_or_powerdown_pin_out,
  input wire irq_or_powerdown_pin_oe,
  input wire irq);
  timeunit 1ns / 1ps;
  // control write that lands; lane 0 carries both control bits
  wire cw = psel && penable && pready && pwrite && paddr == 8'h44 && pstrb[0];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rdy;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("pready not one cycle");
  property p_err;
    pslverr |-> pready && prdata == 32'h0;
  endproperty
  a_err: assert property (p_err) else $error("bad error answer");
  property p_rsv;
    pready && paddr == 8'h48 |-> prdata[31:14] == 18'h0 && prdata[7:6] == 2'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_pin;
    irq_or_powerdown_pin_out == !(irq && irq_or_powerdown_pin_oe);
  endproperty
  a_pin: assert property (p_pin) else $error("pin level wrong");
  property p_hold;
    irq && !psel && !$past(psel) |=> irq;
  endproperty
  a_hold: assert property (p_hold) else $error("irq dropped");
  property p_gate;
    cw && !pwdata[1] |-> ##2 !irq;
  endproperty
  a_gate: assert property (p_gate) else $error("irq not gated");
  property p_oe;
    cw |-> ##2 irq_or_powerdown_pin_oe == $past(pwdata[0], 2);
  endproperty
  a_oe: assert property (p_oe) else $error("pin direction wrong");
  property p_pd;
    cw && !pwdata[0] |-> ##2 irq_or_powerdown_pin_out [*3];
  endproperty
  a_pd: assert property (p_pd) else $error("pin driven in input mode");
  c_irq: cover property ($rose(irq));
  c_err: cover property (pslverr);
  c_pd: cover property (cw && !pwdata[0]);
endmodule
bind phy_event_interrupt_unit phy_event_irq_chk u_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .irq_or_powerdown_pin_out,
  .irq_or_powerdown_pin_oe, .irq);

/* tb/host_pin.sv */
// host side of the shared pin, pulled up when nobody drives it
module host_pin (
  input wire oe,
  input wire out,
  input wire hold_low,
  output wire lvl);
  timeunit 1ns / 1ps;
  assign lvl = oe ? out : !hold_low;
endmodule

/* tb/phy_event_interrupt_unit_tb.sv */
// self-checking bench for the phy event interrupt unit
module phy_event_interrupt_unit_tb;
  timeunit 1ns / 1ps;
  logic pclk, presetn, psel, penable, pwrite, pd, link_status, speed_status;
  logic duplex_status, autoneg_complete;
  logic [7:0] paddr, false_carrier_counter;
  logic [15:0] rx_error_counter;
  logic [31:0] pwdata;
  logic [3:0] pstrb;
  wire [31:0] prdata;
  wire pready, pslverr, pin, pin_out, pin_oe, powerdown_req, irq;
  int miscompares = 0, tests_run = 0;
  always #2.5 pclk = ~pclk;
  phy_event_interrupt_unit u_phy_event_interrupt_unit (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .link_status,
    .speed_status, .duplex_status, .autoneg_complete, .false_carrier_counter,
    .rx_error_counter, .irq_or_powerdown_pin_in(pin), .irq_or_powerdown_pin_out(pin_out),
    .irq_or_powerdown_pin_oe(pin_oe), .powerdown_req, .irq);
  host_pin u_host_pin (.oe(pin_oe), .out(pin_out), .hold_low(pd), .lvl(pin));
  task automatic ck(input string s, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  // reads compare prdata against d, so one task serves both directions
  task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    ck("pslverr", 32'(a != 8'h44 && a != 8'h48), 32'(pslverr));
    ck("prdata", w ? 32'h0 : d, prdata);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic t_regs;
    xf(1'h0, 8'h44, 32'h0);
    xf(1'h0, 8'h48, 32'h0);
    xf(1'h1, 8'hFF, 32'hFFFFFFFF);
    xf(1'h1, 8'h48, 32'hFFFFFFFF);
    xf(1'h0, 8'h48, 32'h3F);
  endtask
  task automatic t_events;
    xf(1'h1, 8'h44, 32'h3);
    for (int i = 0; i < 6; i++) begin
      case (i)
        0: rx_error_counter <= 16'h8000;
        1: false_carrier_counter <= 8'h80;
        2: autoneg_complete <= 1'h1;
        3: duplex_status <= 1'h1;
        4: speed_status <= 1'h1;
        default: link_status <= 1'h1;
      endcase
      repeat (3) @(posedge pclk);
      ck("irq", 32'h1, 32'(irq));
      ck("pin", 32'h0, 32'(pin));
      xf(1'h0, 8'h48, 32'h3F | (32'h100 << i));
      repeat (2) @(posedge pclk);
      ck("irq idle", 32'h0, 32'(irq));
      xf(1'h0, 8'h48, 32'h3F);
    end
  endtask
  task automatic t_gate;
    xf(1'h1, 8'h44, 32'h1);
    link_status <= 1'h0;
    repeat (3) @(posedge pclk);
    ck("irq gated", 32'h0, 32'(irq));
    ck("pin gated", 32'h1, 32'(pin));
    xf(1'h0, 8'h48, 32'h203F);
    xf(1'h1, 8'h44, 32'h3);
    xf(1'h1, 8'h48, 32'h0);
    speed_status <= 1'h0;
    repeat (3) @(posedge pclk);
    ck("irq masked", 32'h0, 32'(irq));
    xf(1'h0, 8'h48, 32'h1000);
    xf(1'h1, 8'h44, 32'h0);
    pd <= 1'h1;
    repeat (5) @(posedge pclk);
    ck("pin_oe", 32'h0, 32'(pin_oe));
    ck("powerdown", 32'h1, 32'(powerdown_req));
    pd <= 1'h0;
    repeat (4) @(posedge pclk);
    ck("powerdown off", 32'h0, 32'(powerdown_req));
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    {pclk, presetn, psel, penable, pwrite, pd, link_status, speed_status} = 8'h00;
    {duplex_status, autoneg_complete, paddr, pwdata, pstrb} = 46'h3;
    // counters start just below half full so the crossing is the boundary case
    {false_carrier_counter, rx_error_counter} = 24'h7F7FFF;
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    t_regs;
    t_events;
    t_gate;
    stop_test;
  end
  // traffic needs some 130 cycles, so 4000 cycles means a hang
  initial begin
    #20000;
    miscompares++;
    stop_test;
  end
endmodule
